/* File: include/pfr_pkg.sv */
// Constants and types for the power-on fault and channel re-map block.
// Assumes a 32-bit classic Wishbone bus, one register per aligned word.
package pfr_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int NUM_CH = 8;
    localparam int CH_PER_GRP = 4;
    localparam int NUM_GRP = 2;
    localparam int ADR_W = 10;
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 8;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_FAULT_G0 = 8'h24;
    localparam logic [7:0] IDX_FAULT_COR_G0 = 8'h25;
    localparam logic [7:0] IDX_MAP_G0 = 8'h26;
    localparam logic [7:0] IDX_FAULT_G1 = 8'h34;
    localparam logic [7:0] IDX_FAULT_COR_G1 = 8'h35;
    localparam logic [7:0] IDX_MAP_G1 = 8'h36;
    localparam logic [7:0] IDX_CAP_EN = 8'h40;
    localparam logic [7:0] IDX_STATUS = 8'h41;
    localparam logic [7:0] IDX_IRQ_EN = 8'h42;
    localparam logic [7:0] IDX_IRQ_CLR = 8'h43;
    localparam logic [7:0] IDX_CAP_BUSY = 8'h44;

    // ------------------------------------------------------------------
    // Reset values and field layout
    // ------------------------------------------------------------------
    localparam logic [7:0] MAP_RESET = 8'hE4;
    localparam logic [7:0] FAULT_RESET = 8'h00;
    localparam logic [7:0] CAP_EN_RESET = 8'h00;
    localparam int ST_W = 18;
    localparam logic [17:0] IRQ_EN_RESET = 18'h00000;
    localparam int ST_CAP_LSB = 0;
    localparam int ST_FAULT_LSB = 8;
    localparam int ST_REJ_LSB = 16;

    // ------------------------------------------------------------------
    // Power-on fault codes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PFR_FC_NONE = 2'b00,
        PFR_FC_BAD_DET = 2'b01,
        PFR_FC_CLASS_ERR = 2'b10,
        PFR_FC_NO_POWER = 2'b11
    } pfr_fault_code_t;

endpackage : pfr_pkg

/* File: core/pfr_quad.sv */
// Fault codes and logical-to-physical map of one group of four channels.
// Assumes event inputs are one-cycle pulses synchronous to clk_i.
`timescale 1ns/100ps
module pfr_quad (
    // Clock and resets
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    // Channel events
    input wire logic [3:0] pwon_fail_i,
    input wire logic [7:0] fault_cause_i,
    input wire logic [3:0] pec_i,
    input wire logic [3:0] turn_off_i,
    input wire logic [3:0] chan_off_i,
    input wire logic [1:0] four_pair_i,
    input wire logic [1:0] single_sig_i,
    // Register access
    input wire logic map_wr_i,
    input wire logic [7:0] map_data_i,
    input wire logic rd_clr_i,
    input wire logic [7:0] rd_snap_i,
    // Results
    output logic [7:0] fault_o,
    output logic [7:0] map_o,
    output logic [3:0] fault_set_o,
    output logic map_rej_o
);

    typedef struct packed {
        logic [7:0] fault;
        logic [7:0] map;
    } pfr_quad_st_t;

    pfr_quad_st_t st_ff;
    pfr_quad_st_t nxt_st;
    logic [3:0] ld;
    logic [7:0] code;
    logic map_ok;

    // ------------------------------------------------------------------
    // Per-channel load decision
    // ------------------------------------------------------------------
    for (genvar c = 0; c < 4; c++) begin : g_ch
        localparam int P = c ^ 1;
        localparam int G = c / 2;
        logic own;
        logic mate;
        // R08: start fault loads only without enable change
        assign own = pwon_fail_i[c] & ~pec_i[c];
        assign mate = pwon_fail_i[P] & ~pec_i[P];
        // R09: single signature updates both channels together
        assign ld[c] = (four_pair_i[G] & single_sig_i[G]) ? (own | mate) : own;
        assign code[2*c+1:2*c] = own ? fault_cause_i[2*c+1:2*c] :
                                       fault_cause_i[2*P+1:2*P];
    end

    // R11: selectors must be distinct within the group
    assign map_ok = (map_data_i[1:0] != map_data_i[3:2]) &&
                    (map_data_i[1:0] != map_data_i[5:4]) &&
                    (map_data_i[1:0] != map_data_i[7:6]) &&
                    (map_data_i[3:2] != map_data_i[5:4]) &&
                    (map_data_i[3:2] != map_data_i[7:6]) &&
                    (map_data_i[5:4] != map_data_i[7:6]);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        for (int c = 0; c < 4; c++) begin
            // R06: record code after a failed power-on attempt
            if (ld[c]) begin
                nxt_st.fault[2*c+:2] = code[2*c+:2];
            // R07: turn-off clears the channel code
            end else if (turn_off_i[c]) begin
                nxt_st.fault[2*c+:2] = pfr_pkg::PFR_FC_NONE;
            // R05: clear-on-read clears what was read
            end else if (rd_clr_i &&
                         st_ff.fault[2*c+:2] == rd_snap_i[2*c+:2]) begin
                nxt_st.fault[2*c+:2] = pfr_pkg::PFR_FC_NONE;
            end
        end
        // R12: write refused unless every channel of the group is off
        if (map_wr_i && (&chan_off_i) && map_ok) begin
            nxt_st.map = map_data_i;
        end
    end

    // R13: map survives the pin reset, only power-on restores it
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            st_ff <= '{fault: pfr_pkg::FAULT_RESET, map: pfr_pkg::MAP_RESET};
        end else if (rst_i) begin
            st_ff <= '{fault: pfr_pkg::FAULT_RESET, map: st_ff.map};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign fault_o = st_ff.fault;
    // R15: logical n selects physical code+1 within the group
    assign map_o = st_ff.map;
    assign fault_set_o = ld;
    assign map_rej_o = map_wr_i & ~((&chan_off_i) & map_ok);

endmodule : pfr_quad

/* File: core/pfr_top.sv */
// Power-on fault status, channel re-map and legacy capacitance control.
// Assumes classic Wishbone master and channel event pulses on clk_i.
//
// Functional notes
// R01: Capacitance measurement runs only in manual/diagnostic mode.
// R02: Skip capacitance measurement when resistance detection is valid.
// R03: Host requests measurement separately for each channel of 4-pair port.
// R04: On finish set capacitance-done flag and update result registers.
// R05: Fault status at two codes: plain read and clear-on-read.
// R06: Failed power-on records two-bit fault code per channel.
// R07: Turning a channel off clears its fault code.
// R08: Start fault loads cause only when enable-change flag is clear.
// R09: Four-pair: dual signature updates individually, single together.
// R10: Eight-bit read/write re-map register, reset value 0xE4 identity.
// R11: Re-mapping stays within its four-channel group.
// R12: Re-map write ignored unless all group channels are off.
// R13: Re-map contents survive pin reset; power-on restores default.
// R14: Host pairs only logical 1 with 2 or 3 with 4.
// R15: Logical n at bits 2n-1:2n-2; selector k means physical k+1.
// R16: Fault codes: ch4 bits 7:6 down to ch1 bits 1:0.
`timescale 1ns/100ps
module pfr_top (
    // Clock and resets
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Interrupt
    output logic irq_o,
    // Capacitance measurement
    input wire logic [7:0] manual_mode_i,
    input wire logic [7:0] res_det_done_i,
    input wire logic [7:0] res_det_valid_i,
    input wire logic [7:0] cap_meas_done_i,
    output logic [7:0] cap_run_o,
    output logic [7:0] cap_result_update_o,
    // Power-on fault sources
    input wire logic [7:0] pwon_fail_i,
    input wire logic [15:0] fault_cause_i,
    input wire logic [7:0] pec_i,
    input wire logic [7:0] turn_off_i,
    input wire logic [7:0] chan_off_i,
    input wire logic [3:0] four_pair_i,
    input wire logic [3:0] single_sig_i,
    // Channel map
    output logic [15:0] chan_map_o
);

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic irq;
        logic [7:0] cap_en;
        logic [7:0] cap_run;
        logic [7:0] cap_upd;
        logic [17:0] status;
        logic [17:0] irq_en;
        logic [15:0] map;
    } pfr_top_st_t;

    pfr_top_st_t st_ff;
    pfr_top_st_t nxt_st;

    logic [7:0] idx;
    logic req;
    logic acc;
    logic wr;
    logic [31:0] wmask;
    logic [7:0] grp_fault [pfr_pkg::NUM_GRP];
    logic [7:0] grp_map [pfr_pkg::NUM_GRP];
    logic [3:0] grp_set [pfr_pkg::NUM_GRP];
    logic grp_rej [pfr_pkg::NUM_GRP];
    logic [pfr_pkg::NUM_GRP-1:0] map_wr;
    logic [pfr_pkg::NUM_GRP-1:0] rd_clr;
    logic [7:0] fault_set;
    logic [1:0] rej_set;
    logic [7:0] cap_done;
    logic [7:0] cap_start;
    logic [31:0] rd_data;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    assign idx = adr_i[pfr_pkg::IDX_LSB+:pfr_pkg::IDX_W];
    assign req = cyc_i & stb_i & ~st_ff.ack;
    // Writes and read side effects land on the edge that closes ack
    assign acc = cyc_i & stb_i & st_ff.ack;
    assign wr = acc & we_i;
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}},
                    {8{sel_i[1]}}, {8{sel_i[0]}}};

    // ------------------------------------------------------------------
    // Channel groups
    // ------------------------------------------------------------------
    for (genvar g = 0; g < pfr_pkg::NUM_GRP; g++) begin : g_grp
        localparam logic [7:0] IDX_MAP = (g == 0) ?
            pfr_pkg::IDX_MAP_G0 : pfr_pkg::IDX_MAP_G1;
        localparam logic [7:0] IDX_COR = (g == 0) ?
            pfr_pkg::IDX_FAULT_COR_G0 : pfr_pkg::IDX_FAULT_COR_G1;
        // R10: re-map register write
        assign map_wr[g] = wr & sel_i[0] & (idx == IDX_MAP);
        // R05: clear-on-read code clears after the answer
        assign rd_clr[g] = acc & ~we_i & (idx == IDX_COR);

        // R11: each group re-maps only within itself
        pfr_quad pfr_quad_i (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .por_i(por_i),
            .pwon_fail_i(pwon_fail_i[4*g+:4]),
            .fault_cause_i(fault_cause_i[8*g+:8]),
            .pec_i(pec_i[4*g+:4]),
            .turn_off_i(turn_off_i[4*g+:4]),
            .chan_off_i(chan_off_i[4*g+:4]),
            .four_pair_i(four_pair_i[2*g+:2]),
            .single_sig_i(single_sig_i[2*g+:2]),
            .map_wr_i(map_wr[g]),
            .map_data_i(dat_i[7:0]),
            .rd_clr_i(rd_clr[g]),
            .rd_snap_i(st_ff.dat[7:0]),
            .fault_o(grp_fault[g]),
            .map_o(grp_map[g]),
            .fault_set_o(grp_set[g]),
            .map_rej_o(grp_rej[g])
        );

        assign fault_set[4*g+:4] = grp_set[g];
        assign rej_set[g] = grp_rej[g];
    end

    // ------------------------------------------------------------------
    // Capacitance measurement control
    // ------------------------------------------------------------------
    for (genvar c = 0; c < pfr_pkg::NUM_CH; c++) begin : g_cap
        // R01: start only for an enabled channel in manual mode
        // R02: a valid resistance result skips the measurement
        assign cap_start[c] = res_det_done_i[c] & ~res_det_valid_i[c] &
                              manual_mode_i[c] & st_ff.cap_en[c] &
                              ~st_ff.cap_run[c];
        // R04: finish counted only for a running measurement
        assign cap_done[c] = cap_meas_done_i[c] & st_ff.cap_run[c] &
                             manual_mode_i[c];
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        rd_data = 32'h00000000;
        unique case (idx)
            // R16: fault codes, channel 4 in the top bits
            pfr_pkg::IDX_FAULT_G0,
            pfr_pkg::IDX_FAULT_COR_G0: begin
                rd_data[7:0] = grp_fault[0];
            end
            pfr_pkg::IDX_FAULT_G1,
            pfr_pkg::IDX_FAULT_COR_G1: begin
                rd_data[7:0] = grp_fault[1];
            end
            pfr_pkg::IDX_MAP_G0: begin
                rd_data[7:0] = grp_map[0];
            end
            pfr_pkg::IDX_MAP_G1: begin
                rd_data[7:0] = grp_map[1];
            end
            pfr_pkg::IDX_CAP_EN: begin
                rd_data[7:0] = st_ff.cap_en;
            end
            pfr_pkg::IDX_STATUS: begin
                rd_data[pfr_pkg::ST_W-1:0] = st_ff.status;
            end
            pfr_pkg::IDX_IRQ_EN: begin
                rd_data[pfr_pkg::ST_W-1:0] = st_ff.irq_en;
            end
            pfr_pkg::IDX_CAP_BUSY: begin
                rd_data[7:0] = st_ff.cap_run;
            end
            default: begin
                rd_data = 32'h00000000;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = req;
        nxt_st.dat = req ? rd_data : 32'h00000000;
        nxt_st.cap_upd = 8'h00;

        // Software registers
        if (wr && idx == pfr_pkg::IDX_CAP_EN && sel_i[0]) begin
            nxt_st.cap_en = dat_i[7:0];
        end
        if (wr && idx == pfr_pkg::IDX_IRQ_EN) begin
            nxt_st.irq_en = (st_ff.irq_en & ~wmask[pfr_pkg::ST_W-1:0]) |
                            (dat_i[pfr_pkg::ST_W-1:0] &
                             wmask[pfr_pkg::ST_W-1:0]);
        end
        if (wr && idx == pfr_pkg::IDX_IRQ_CLR) begin
            nxt_st.status = st_ff.status &
                            ~(dat_i[pfr_pkg::ST_W-1:0] &
                              wmask[pfr_pkg::ST_W-1:0]);
        end

        // R01: leaving manual mode ends a running measurement
        nxt_st.cap_run = (st_ff.cap_run & manual_mode_i & ~cap_done) |
                         cap_start;
        // R04: done flag and result update on finish
        nxt_st.cap_upd = cap_done;

        // Events set after the clear so that a set wins
        nxt_st.status[pfr_pkg::ST_CAP_LSB+:8] =
            nxt_st.status[pfr_pkg::ST_CAP_LSB+:8] | cap_done;
        nxt_st.status[pfr_pkg::ST_FAULT_LSB+:8] =
            nxt_st.status[pfr_pkg::ST_FAULT_LSB+:8] | fault_set;
        // R12: refused re-map write is reported
        nxt_st.status[pfr_pkg::ST_REJ_LSB+:2] =
            nxt_st.status[pfr_pkg::ST_REJ_LSB+:2] | (rej_set & map_wr);

        nxt_st.irq = |(nxt_st.status & nxt_st.irq_en);
        nxt_st.map = {grp_map[1], grp_map[0]};
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) begin
            st_ff.ack <= 1'b0;
            st_ff.dat <= 32'h00000000;
            st_ff.irq <= 1'b0;
            st_ff.cap_en <= pfr_pkg::CAP_EN_RESET;
            st_ff.cap_run <= 8'h00;
            st_ff.cap_upd <= 8'h00;
            st_ff.status <= 18'h00000;
            st_ff.irq_en <= pfr_pkg::IRQ_EN_RESET;
            // R13: mirror follows the retained map
            st_ff.map <= por_i ? {2{pfr_pkg::MAP_RESET}} : st_ff.map;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign ack_o = st_ff.ack;
    assign dat_o = st_ff.dat;
    assign irq_o = st_ff.irq;
    assign cap_run_o = st_ff.cap_run;
    assign cap_result_update_o = st_ff.cap_upd;
    // R15: two-bit selector per logical channel, group 0 low
    assign chan_map_o = st_ff.map;

endmodule : pfr_top

/* File: testbench/pfr_properties.sv */
// Concurrent checks on the fault, re-map and capacitance block ports.
// Assumes one clock, both resets synchronous and active high.
`timescale 1ns/100ps
module pfr_properties (
    // Clock and resets
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    // Bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Channels
    input wire logic [7:0] chan_off_i,
    input wire logic [7:0] manual_mode_i,
    input wire logic [7:0] res_det_done_i,
    input wire logic [7:0] res_det_valid_i,
    input wire logic [7:0] cap_meas_done_i,
    input wire logic [7:0] cap_run_o,
    input wire logic [7:0] cap_result_update_o,
    input wire logic [15:0] chan_map_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || por_i);
    // ------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------
    sequence s_taken;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_map_blocked;
        cyc_i && stb_i && we_i && ack_o
            && adr_i[9:2] == pfr_pkg::IDX_MAP_G0 && chan_off_i[3:0] != 4'hF;
    endsequence
    sequence s_cap_done;
        (cap_run_o & manual_mode_i & cap_meas_done_i) != 8'h00;
    endsequence
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_ack_follows_req: assert property (s_taken |=> ack_o)
        else $error("request not acked in next cycle");
    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h00000000)
        else $error("read data outside ack cycle");
    a_map_por_default: assert property (
        @(posedge clk_i) disable iff (rst_i) por_i |=> chan_map_o == 16'hE4E4)
        else $error("map not default after power-on reset");
    a_map_pin_keep: assert property (
        @(posedge clk_i) disable iff (por_i) rst_i |=> $stable(chan_map_o))
        else $error("map changed by pin reset");
    a_map_wr_refused: assert property (
        s_map_blocked |-> ##2 $stable(chan_map_o[7:0]))
        else $error("map written while a channel is on");
    a_cap_start_cond: assert property (
        (cap_run_o & ~$past(cap_run_o) & ~$past(manual_mode_i
            & res_det_done_i & ~res_det_valid_i)) == 8'h00)
        else $error("capacitance run started without cause");
    a_cap_done_update: assert property (s_cap_done |=>
        cap_result_update_o == $past(cap_run_o & manual_mode_i
            & cap_meas_done_i))
        else $error("result update does not match finished runs");
endmodule : pfr_properties

/* File: testbench/pfr_cap_engine.sv */
// Behavioural capacitance engine on the channel side of the block.
// Assumes cap_run_i registered on clk_i; answers DLY+1 cycles after cap_run_i rises.
`timescale 1ns/100ps
module pfr_cap_engine #(
    parameter int DLY = 3
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Engine
    input wire logic [7:0] cap_run_i,
    output logic [7:0] cap_meas_done_o
);
    logic [7:0] cnt [8];
    always @(posedge clk_i) begin
        for (int i = 0; i < 8; i++) begin
            cap_meas_done_o[i] <= 1'b0;
            if (rst_i || !cap_run_i[i]) begin
                cnt[i] <= 8'h00;
            end else if (cnt[i] <= DLY[7:0]) begin
                cnt[i] <= cnt[i] + 8'h01;
                cap_meas_done_o[i] <= (cnt[i] == DLY[7:0]);
            end
        end
    end
endmodule : pfr_cap_engine

/* File: testbench/pfr_top_test.sv */
// Self-checking bench for the fault, re-map and capacitance block.
// Assumes a classic Wishbone slave answering one cycle after a request.
`timescale 1ns/100ps
module pfr_top_test;
    logic clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, irq_o;
    logic [9:0] adr_i = 10'h000;
    logic [3:0] sel_i = 4'h0, four_pair_i = 4'h0, single_sig_i = 4'h0;
    logic [31:0] dat_i = 32'h00000000, dat_o;
    logic [7:0] manual_mode_i = 8'h00, res_det_done_i = 8'h00;
    logic [7:0] res_det_valid_i = 8'h00, cap_meas_done_i, cap_run_o;
    logic [7:0] cap_result_update_o, pwon_fail_i = 8'h00, pec_i = 8'h00;
    logic [7:0] turn_off_i = 8'h00, chan_off_i = 8'hFF;
    logic [15:0] fault_cause_i = 16'h0000, chan_map_o;
    logic [31:0] r;
    int n_errors = 0, n_compared = 0;

    always #5 clk_i = ~clk_i;

    pfr_top pfr_top_i (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .irq_o(irq_o), .manual_mode_i(manual_mode_i),
        .res_det_done_i(res_det_done_i), .res_det_valid_i(res_det_valid_i),
        .cap_meas_done_i(cap_meas_done_i), .cap_run_o(cap_run_o),
        .cap_result_update_o(cap_result_update_o),
        .pwon_fail_i(pwon_fail_i), .fault_cause_i(fault_cause_i),
        .pec_i(pec_i), .turn_off_i(turn_off_i), .chan_off_i(chan_off_i),
        .four_pair_i(four_pair_i), .single_sig_i(single_sig_i),
        .chan_map_o(chan_map_o));
    pfr_cap_engine #(.DLY(3)) pfr_cap_engine_i (.clk_i(clk_i),
        .rst_i(rst_i), .cap_run_i(cap_run_o),
        .cap_meas_done_o(cap_meas_done_i));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task conclude;
        $display("n_errors=%0d n_compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task wb(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb
    task rd(input logic [9:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h00000000);
        check(r, exp);
    endtask : rd
    task fail(input logic [7:0] ch, input logic [15:0] cause);
        @(posedge clk_i);
        pwon_fail_i <= ch;
        fault_cause_i <= cause;
        @(posedge clk_i);
        pwon_fail_i <= 8'h00;
    endtask : fail
    task off(input logic [7:0] ch);
        @(posedge clk_i);
        turn_off_i <= ch;
        @(posedge clk_i);
        turn_off_i <= 8'h00;
    endtask : off
    task det(input logic [7:0] ch, input logic [7:0] vld, input logic run);
        @(posedge clk_i);
        res_det_done_i <= ch;
        res_det_valid_i <= vld;
        @(posedge clk_i);
        res_det_done_i <= 8'h00;
        @(posedge clk_i);
        check({31'h0, |cap_run_o}, {31'h0, run});
        for (int i = 0; i < 20 && cap_run_o != 8'h00; i++) @(posedge clk_i);
        repeat (2) @(posedge clk_i);
    endtask : det
    task do_reset(input logic p);
        @(posedge clk_i);
        rst_i <= ~p;
        por_i <= p;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
    endtask : do_reset

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        #100000;
        n_errors++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        rd(10'h090, 32'h0);
        rd(10'h094, 32'h0);
        rd(10'h098, 32'hE4);
        rd(10'h0D8, 32'hE4);
        wb(1'b1, 10'h3FC, 32'hFF);
        rd(10'h3FC, 32'h0);
        fail(8'h0F, 16'h0079);
        rd(10'h090, 32'h79);
        rd(10'h090, 32'h79);
        rd(10'h104, 32'h00F00);
        check({31'h0, irq_o}, 32'h0);
        wb(1'b1, 10'h108, 32'h100);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        wb(1'b1, 10'h10C, 32'h3FFFF);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        rd(10'h104, 32'h0);
        rd(10'h094, 32'h79);
        rd(10'h090, 32'h0);
        @(posedge clk_i) pec_i <= 8'h01;
        fail(8'h01, 16'h0003);
        rd(10'h090, 32'h0);
        @(posedge clk_i) pec_i <= 8'h00;
        fail(8'h02, 16'h0008);
        rd(10'h090, 32'h08);
        off(8'h02);
        rd(10'h090, 32'h0);
        fail(8'h10, 16'h0300);
        rd(10'h0D0, 32'h03);
        rd(10'h090, 32'h0);
        off(8'h10);
        // only logical 1 with 2 paired
        @(posedge clk_i) four_pair_i <= 4'h1;
        single_sig_i <= 4'h1;
        fail(8'h01, 16'h0001);
        rd(10'h090, 32'h05);
        off(8'h03);
        @(posedge clk_i) single_sig_i <= 4'h0;
        fail(8'h01, 16'h0002);
        rd(10'h090, 32'h02);
        off(8'h01);
        wb(1'b1, 10'h10C, 32'h3FFFF);
        wb(1'b1, 10'h098, 32'h1B);
        rd(10'h098, 32'h1B);
        @(posedge clk_i) chan_off_i <= 8'hFB;
        wb(1'b1, 10'h098, 32'hE4);
        rd(10'h098, 32'h1B);
        @(posedge clk_i) chan_off_i <= 8'hFF;
        wb(1'b1, 10'h098, 32'h00);
        rd(10'h098, 32'h1B);
        rd(10'h104, 32'h10000);
        wb(1'b1, 10'h0D8, 32'h4E);
        // Map output mirror trails the register by one cycle
        repeat (2) @(posedge clk_i);
        check({16'h0, chan_map_o}, 32'h4E1B);
        do_reset(1'b0);
        rd(10'h098, 32'h1B);
        check({16'h0, chan_map_o}, 32'h4E1B);
        do_reset(1'b1);
        check({16'h0, chan_map_o}, 32'hE4E4);
        rd(10'h098, 32'hE4);
        wb(1'b1, 10'h100, 32'h07);
        @(posedge clk_i) manual_mode_i <= 8'h03;
        det(8'h01, 8'h01, 1'b0);
        rd(10'h104, 32'h0);
        det(8'h01, 8'h00, 1'b1);
        rd(10'h104, 32'h1);
        // second channel of the port asked on its own
        det(8'h02, 8'h00, 1'b1);
        rd(10'h104, 32'h3);
        det(8'h04, 8'h00, 1'b0);
        rd(10'h104, 32'h3);
        rd(10'h110, 32'h0);
        conclude();
    end
endmodule : pfr_top_test

bind pfr_top pfr_properties pfr_properties_i (.clk_i(clk_i),
    .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .chan_off_i(chan_off_i), .manual_mode_i(manual_mode_i),
    .res_det_done_i(res_det_done_i), .res_det_valid_i(res_det_valid_i),
    .cap_meas_done_i(cap_meas_done_i), .cap_run_o(cap_run_o),
    .cap_result_update_o(cap_result_update_o), .chan_map_o(chan_map_o));
